/* File: rtl/gpio_event_port.sv */
// shared gpio block: pin registers, input filter, level events, arbiter
// assumes each core presents one-cycle requests and each thread controller
// returns an accept pulse for a pending thread request
`default_nettype none
module gpio_event_port
  import gpio_event_pkg::*;
#(
  parameter int CORES = NUM_CORES
) (
  input wire logic CLK,
  input wire logic RSTN,
  input wire core_req_t [CORES-1:0] CORE_REQ,
  output core_rsp_t [CORES-1:0] CORE_RSP,
  input wire logic [NUM_PINS-1:0] PIN_IN,
  output logic [NUM_PINS-1:0] PIN_OUT,
  output logic [NUM_PINS-1:0] PIN_OE,
  output thread_req_t [CORES-1:0] THREAD_REQ,
  input wire logic [CORES-1:0] THREAD_ACCEPT
);
  localparam int EV_PINS = EVENT_BANKS * PINS_PER_BANK;
  localparam int CW = (CORES > 1) ? $clog2(CORES) : 1;
  localparam logic [31:0] WINDOW = BANK_STRIDE * NUM_BANKS;
  localparam logic [3:0] READY_AT = 4'(EVENT_DELAY - 3);
  localparam logic [3:0] READ_AT = 4'(READ_LATENCY - 2);

  // ----------------------------------------------------------------
  // pin state
  // ----------------------------------------------------------------
  logic [NUM_PINS-1:0] dir_q;
  logic [NUM_PINS-1:0] out_q;
  logic [NUM_PINS-1:0] meta_q;
  logic [NUM_PINS-1:0] sh1_q;
  logic [NUM_PINS-1:0] sh2_q;
  logic [NUM_PINS-1:0] sh3_q;
  logic [NUM_PINS-1:0] filt;
  logic [NUM_PINS-1:0] dir_set;
  logic [NUM_PINS-1:0] dir_clr;
  logic [NUM_PINS-1:0] out_set;
  logic [NUM_PINS-1:0] out_clr;

  // ----------------------------------------------------------------
  // event state
  // ----------------------------------------------------------------
  logic [EV_PINS-1:0] arm_lo_q;
  logic [EV_PINS-1:0] arm_hi_q;
  logic [EV_PINS-1:0] wait_q;
  logic [EV_PINS-1:0] ready_q;
  logic [EV_PINS-1:0] cap_q;
  logic [EV_PINS-1:0] arm_lo_set;
  logic [EV_PINS-1:0] arm_hi_set;
  logic [EV_PINS-1:0] cap_clr;
  logic [EV_PINS-1:0] match;
  logic [EV_PINS-1:0] granted;
  logic [CW-1:0] owner_q [EV_PINS];
  logic [CW-1:0] owner_d [EV_PINS];
  logic [EV_PINS-1:0] owner_we;
  logic [3:0] cnt_q [EV_PINS];
  logic [START_W-1:0] start_q [CORES];
  logic [CORES-1:0] start_we;
  logic [6:0] rr_ptr_q;
  logic grant_v;
  logic [6:0] grant_idx;

  // ----------------------------------------------------------------
  // read path state
  // ----------------------------------------------------------------
  logic [CORES-1:0] rd_busy_q;
  logic [3:0] rd_cnt_q [CORES];
  logic [31:0] rd_hold_q [CORES];

  assign PIN_OUT = out_q;
  assign PIN_OE = dir_q;

  // ----------------------------------------------------------------
  // write decode, all cores in parallel
  // ----------------------------------------------------------------
  // one shared window for every core; same-cycle writes merge, except the pin owner
  always_comb begin
    logic [31:0] rel;
    logic [3:0] b;
    logic [7:0] off;
    logic [7:0] d;
    rel = '0;
    b = '0;
    off = '0;
    d = '0;
    dir_set = '0;
    dir_clr = '0;
    out_set = '0;
    out_clr = '0;
    arm_lo_set = '0;
    arm_hi_set = '0;
    cap_clr = '0;
    owner_we = '0;
    start_we = '0;
    for (int p = 0; p < EV_PINS; p++) begin
      owner_d[p] = owner_q[p];
    end
    for (int c = 0; c < CORES; c++) begin
      rel = CORE_REQ[c].addr - BASE_ADDR;
      b = rel[11:8];
      off = rel[7:0];
      d = CORE_REQ[c].wdata[7:0];
      if (CORE_REQ[c].req && CORE_REQ[c].we) begin
        if (rel == EVENT_ADDR_OFF) begin
          start_we[c] = 1'b1;
        end else if (rel < WINDOW) begin
          case (off)
            OFF_DIR_SET: dir_set[b*8+:8] = dir_set[b*8+:8] | d;
            OFF_DIR_CLR: dir_clr[b*8+:8] = dir_clr[b*8+:8] | d;
            OFF_OUT_SET: out_set[b*8+:8] = out_set[b*8+:8] | d;
            OFF_OUT_CLR: out_clr[b*8+:8] = out_clr[b*8+:8] | d;
            default: ;
          endcase
          if (int'(b) < EVENT_BANKS) begin
            case (off)
              OFF_ARM_LOW: arm_lo_set[b*8+:8] = arm_lo_set[b*8+:8] | d;
              OFF_ARM_HIGH: arm_hi_set[b*8+:8] = arm_hi_set[b*8+:8] | d;
              OFF_CAPTURE: cap_clr[b*8+:8] = cap_clr[b*8+:8] | d;
              default: ;
            endcase
            if (off == OFF_ARM_LOW || off == OFF_ARM_HIGH) begin
              for (int j = 0; j < PINS_PER_BANK; j++) begin
                // higher core index wins a same-cycle tie
                if (d[j]) begin
                  owner_we[b*8+j] = 1'b1;
                  owner_d[b*8+j] = CW'(c);
                end
              end
            end
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // direction and output registers
  // ----------------------------------------------------------------
  // set wins when both strobes hit one bit in the same cycle
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      dir_q <= {NUM_BANKS{DIR_RESET}};
      out_q <= {NUM_BANKS{OUT_RESET}};
    end else begin
      dir_q <= (dir_q & ~dir_clr) | dir_set;
      out_q <= (out_q & ~out_clr) | out_set;
    end
  end

  // ----------------------------------------------------------------
  // input filter
  // ----------------------------------------------------------------
  // meta_q only resynchronises; the vote looks at the three stages after it
  // the extra front flop costs one cycle of input delay but keeps the
  // vote free of metastable values
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      meta_q <= '0;
      sh1_q <= '0;
      sh2_q <= '0;
      sh3_q <= '0;
    end else begin
      meta_q <= PIN_IN;
      sh1_q <= meta_q;
      sh2_q <= sh1_q;
      sh3_q <= sh2_q;
    end
  end

  assign filt = (sh1_q & sh2_q) | (sh1_q & sh3_q) | (sh2_q & sh3_q);

  // ----------------------------------------------------------------
  // per-pin level detection, delay and capture
  // ----------------------------------------------------------------
  // detection is gated while an event of the pin is still in flight,
  // so a second match waits instead of overwriting the first
  genvar g;
  generate
    for (g = 0; g < EV_PINS; g++) begin : g_ev
      localparam int SRC = (g / 8) * 8 + ((g % 8) + 7) % 8;
      assign match[g] = ~wait_q[g] & ~ready_q[g] &
                        ((arm_lo_q[g] & ~filt[g]) |
                         (arm_hi_q[g] & filt[g]));
      always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
          arm_lo_q[g] <= 1'b0;
          arm_hi_q[g] <= 1'b0;
        end else begin
          // one-shot: a match disarms, a fresh write re-arms
          arm_lo_q[g] <= (arm_lo_q[g] & ~match[g]) | arm_lo_set[g];
          arm_hi_q[g] <= (arm_hi_q[g] & ~match[g]) | arm_hi_set[g];
        end
      end
      always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
          owner_q[g] <= '0;
        end else if (owner_we[g]) begin
          owner_q[g] <= owner_d[g];
        end
      end
      always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
          wait_q[g] <= 1'b0;
          ready_q[g] <= 1'b0;
          cnt_q[g] <= '0;
        end else if (match[g]) begin
          wait_q[g] <= 1'b1;
          cnt_q[g] <= '0;
        end else if (wait_q[g]) begin
          cnt_q[g] <= cnt_q[g] + 4'h1;
          if (cnt_q[g] == READY_AT) begin
            wait_q[g] <= 1'b0;
            ready_q[g] <= 1'b1;
          end
        end else if (granted[g]) begin
          ready_q[g] <= 1'b0;
        end
      end
      // capture beats a same-cycle clear from software
      always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
          cap_q[g] <= 1'b0;
        end else if (match[SRC]) begin
          cap_q[g] <= filt[g];
        end else if (cap_clr[g]) begin
          cap_q[g] <= 1'b0;
        end
      end
      assign granted[g] = grant_v && (grant_idx == 7'(g));
    end
  endgenerate

  // ----------------------------------------------------------------
  // round-robin arbiter
  // ----------------------------------------------------------------
  // a ready pin whose core slot is still busy is skipped, not dropped,
  // so one blocked core never stalls events owed to the others
  always_comb begin
    int idx;
    idx = 0;
    grant_v = 1'b0;
    grant_idx = '0;
    for (int i = 0; i < EV_PINS; i++) begin
      idx = (int'(rr_ptr_q) + 1 + i) % EV_PINS;
      if (!grant_v && ready_q[idx] &&
          !THREAD_REQ[owner_q[idx]].valid) begin
        grant_v = 1'b1;
        grant_idx = 7'(idx);
      end
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      rr_ptr_q <= 7'(EV_PINS - 1);
    end else if (grant_v) begin
      rr_ptr_q <= grant_idx;
    end
  end

  // ----------------------------------------------------------------
  // per-core start address and thread request slot
  // ----------------------------------------------------------------
  // one slot per core: a further event for a busy core waits in ready_q
  generate
    for (g = 0; g < CORES; g++) begin : g_core
      always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
          start_q[g] <= START_RESET;
        end else if (start_we[g]) begin
          start_q[g] <= CORE_REQ[g].wdata[START_W-1:0];
        end
      end
      always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
          THREAD_REQ[g] <= '0;
        end else if (THREAD_REQ[g].valid) begin
          if (THREAD_ACCEPT[g]) begin
            THREAD_REQ[g].valid <= 1'b0;
          end
        end else if (grant_v && owner_q[grant_idx] == CW'(g)) begin
          THREAD_REQ[g].valid <= 1'b1;
          THREAD_REQ[g].start_addr <= start_q[g];
          THREAD_REQ[g].pin_index <= grant_idx;
        end
      end

      // ------------------------------------------------------------
      // read path, fixed latency
      // ------------------------------------------------------------
      // data is sampled when the read is taken; a read while busy is
      // ignored, which the core never does as it waits for the answer
      always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
          rd_busy_q[g] <= 1'b0;
          rd_cnt_q[g] <= '0;
          rd_hold_q[g] <= '0;
          CORE_RSP[g] <= '0;
        end else begin
          CORE_RSP[g].rvalid <= 1'b0;
          if (rd_busy_q[g]) begin
            rd_cnt_q[g] <= rd_cnt_q[g] + 4'h1;
            if (rd_cnt_q[g] == READ_AT) begin
              rd_busy_q[g] <= 1'b0;
              CORE_RSP[g].rvalid <= 1'b1;
              CORE_RSP[g].rdata <= rd_hold_q[g];
            end
          end else if (CORE_REQ[g].req && !CORE_REQ[g].we) begin
            rd_busy_q[g] <= 1'b1;
            rd_cnt_q[g] <= '0;
            rd_hold_q[g] <= read_word(CORE_REQ[g].addr, g);
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  function automatic logic [31:0] read_word(input logic [31:0] addr,
                                            input int core);
    logic [31:0] rel;
    logic [3:0] b;
    logic [31:0] r;
    rel = addr - BASE_ADDR;
    b = rel[11:8];
    r = '0;
    if (rel == EVENT_ADDR_OFF) begin
      r = {18'h0_0000, start_q[core]};
    end else if (rel < WINDOW) begin
      if (rel[7:0] == OFF_PIN_IN) begin
        r = {24'h00_0000, filt[b*8+:8]};
      end else if (rel[7:0] == OFF_CAPTURE && int'(b) < EVENT_BANKS) begin
        r = {24'h00_0000, cap_q[b*8+:8]};
      end
    end
    return r;
  endfunction
endmodule
`default_nettype wire

/* File: rtl/gpio_event_pkg.sv */
// constants, register layout and carrier types of the shared gpio block
// assumes a single system clock and per-core memory-mapped access ports
`default_nettype none
package gpio_event_pkg;
  localparam int NUM_BANKS = 14;
  localparam int PINS_PER_BANK = 8;
  localparam int NUM_PINS = 112;
  localparam int EVENT_BANKS = 9;
  localparam int NUM_CORES = 4;
  localparam int FILTER_STAGES = 3;
  localparam int READ_LATENCY = 8;
  localparam int EVENT_DELAY = 8;
  localparam int START_W = 14;
  localparam int INDEX_W = 7;
  localparam logic [31:0] BASE_ADDR = 32'h8003_1000;
  localparam logic [31:0] BANK_STRIDE = 32'h0000_0100;
  localparam logic [31:0] EVENT_ADDR_OFF = 32'h0000_0E00;
  localparam logic [7:0] OFF_DIR_CLR = 8'h00;
  localparam logic [7:0] OFF_DIR_SET = 8'h04;
  localparam logic [7:0] OFF_OUT_CLR = 8'h10;
  localparam logic [7:0] OFF_OUT_SET = 8'h14;
  localparam logic [7:0] OFF_PIN_IN = 8'h20;
  localparam logic [7:0] OFF_ARM_LOW = 8'h30;
  localparam logic [7:0] OFF_ARM_HIGH = 8'h34;
  localparam logic [7:0] OFF_CAPTURE = 8'h40;
  localparam logic [7:0] DIR_RESET = 8'h00;
  localparam logic [7:0] OUT_RESET = 8'h00;
  localparam logic [13:0] START_RESET = 14'h0000;

  typedef struct packed {
    logic req;
    logic we;
    logic [31:0] addr;
    logic [31:0] wdata;
  } core_req_t;

  typedef struct packed {
    logic rvalid;
    logic [31:0] rdata;
  } core_rsp_t;

  typedef struct packed {
    logic valid;
    logic [START_W-1:0] start_addr;
    logic [INDEX_W-1:0] pin_index;
  } thread_req_t;
endpackage
`default_nettype wire

/* File: verification/gpio_event_port_chk.sv */
// concurrent checks on the core 0 register path and the core 0 thread request
// assumes it is bound to gpio_event_port and sees only its ports
`default_nettype none
module gpio_event_port_chk
  import gpio_event_pkg::*;
#(
  parameter int CORES = NUM_CORES
) (
  input wire logic CLK,
  input wire logic RSTN,
  input wire core_req_t [CORES-1:0] CORE_REQ,
  input wire core_rsp_t [CORES-1:0] CORE_RSP,
  input wire logic [NUM_PINS-1:0] PIN_IN,
  input wire logic [NUM_PINS-1:0] PIN_OUT,
  input wire logic [NUM_PINS-1:0] PIN_OE,
  input wire thread_req_t [CORES-1:0] THREAD_REQ,
  input wire logic [CORES-1:0] THREAD_ACCEPT
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  // ----------------------------------------------------------
  // helper logic
  // ----------------------------------------------------------
  logic wr0;
  logic [7:0] off0;
  logic [3:0] rd_cnt_q;
  logic [3:0] bank_q;
  logic [7:0] dat_q;
  logic [7:0] oe_was_q;
  logic [7:0] oe_sel;
  logic [7:0] out_sel;
  assign off0 = CORE_REQ[0].addr[7:0];
  assign wr0 = CORE_REQ[0].req && CORE_REQ[0].we &&
    CORE_REQ[0].addr[31:12] == BASE_ADDR[31:12] &&
    CORE_REQ[0].addr[11:8] < 4'(NUM_BANKS);
  assign oe_sel = PIN_OE[{bank_q, 3'b000} +: 8];
  assign out_sel = PIN_OUT[{bank_q, 3'b000} +: 8];
  // a read in the answer cycle is taken, so reload from one as well
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      rd_cnt_q <= 4'h0;
    end else if (CORE_REQ[0].req && !CORE_REQ[0].we && rd_cnt_q <= 4'h1) begin
      rd_cnt_q <= 4'h8;
    end else if (rd_cnt_q != 4'h0) begin
      rd_cnt_q <= rd_cnt_q - 4'h1;
    end
  end
  always_ff @(posedge CLK) begin
    bank_q <= CORE_REQ[0].addr[11:8];
    dat_q <= CORE_REQ[0].wdata[7:0];
    oe_was_q <= PIN_OE[{CORE_REQ[0].addr[11:8], 3'b000} +: 8];
  end
  // ----------------------------------------------------------
  // properties
  // ----------------------------------------------------------
  property p_reset_idle;
    $rose(RSTN) |-> PIN_OE == '0 && PIN_OUT == '0 && THREAD_REQ == '0;
  endproperty
  a_reset_idle: assert property (p_reset_idle)
    else $error("pins not idle after reset");
  property p_rd_lat;
    CORE_RSP[0].rvalid == (rd_cnt_q == 4'h1);
  endproperty
  a_rd_lat: assert property (p_rd_lat)
    else $error("read answer not eight cycles after request");
  property p_dir_set;
    wr0 && off0 == OFF_DIR_SET |=> (oe_sel & dat_q) == dat_q;
  endproperty
  a_dir_set: assert property (p_dir_set)
    else $error("direction set missed");
  property p_dir_clr;
    wr0 && off0 == OFF_DIR_CLR |=> (oe_sel & dat_q) == 8'h00;
  endproperty
  a_dir_clr: assert property (p_dir_clr)
    else $error("direction clear missed");
  property p_out_set;
    wr0 && off0 == OFF_OUT_SET |=> (out_sel & dat_q) == dat_q;
  endproperty
  a_out_set: assert property (p_out_set)
    else $error("output set missed");
  property p_out_clr;
    wr0 && off0 == OFF_OUT_CLR |=> (out_sel & dat_q) == 8'h00;
  endproperty
  a_out_clr: assert property (p_out_clr)
    else $error("output clear missed");
  property p_zero_keep;
    wr0 && (off0 == OFF_DIR_SET || off0 == OFF_DIR_CLR)
      |=> ((oe_sel ^ oe_was_q) & ~dat_q) == 8'h00;
  endproperty
  a_zero_keep: assert property (p_zero_keep)
    else $error("zero bit changed a direction");
  property p_req_hold;
    THREAD_REQ[0].valid && !THREAD_ACCEPT[0] |=> $stable(THREAD_REQ[0]);
  endproperty
  a_req_hold: assert property (p_req_hold)
    else $error("thread request dropped before accept");
  c_read: cover property (CORE_RSP[0].rvalid);
  c_dir: cover property (wr0 && off0 == OFF_DIR_SET);
  c_accept: cover property (THREAD_REQ[0].valid && THREAD_ACCEPT[0]);
endmodule
bind gpio_event_port gpio_event_port_chk #(.CORES(CORES)) chk_u (
  .CLK(CLK), .RSTN(RSTN), .CORE_REQ(CORE_REQ), .CORE_RSP(CORE_RSP),
  .PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE),
  .THREAD_REQ(THREAD_REQ), .THREAD_ACCEPT(THREAD_ACCEPT));
`default_nettype wire

/* File: verification/pin_board_model.sv */
// board pins and per-core thread controllers facing the gpio block
// assumes the bench sets the external level of every released pin
`default_nettype none
module pin_board_model
  import gpio_event_pkg::*;
#(
  parameter int CORES = NUM_CORES
) (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic [NUM_PINS-1:0] EXT_LEVEL,
  input wire logic [3:0] ACCEPT_DELAY,
  input wire logic [NUM_PINS-1:0] PIN_OUT,
  input wire logic [NUM_PINS-1:0] PIN_OE,
  input wire thread_req_t [CORES-1:0] THREAD_REQ,
  output logic [NUM_PINS-1:0] PIN_IN,
  output logic [CORES-1:0] THREAD_ACCEPT
);
  logic [3:0] wait_q [CORES];
  // a driven pin reads back what the block drives
  assign PIN_IN = (PIN_OE & PIN_OUT) | (~PIN_OE & EXT_LEVEL);
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      for (int c = 0; c < CORES; c++) begin
        wait_q[c] <= 4'h0;
      end
    end else begin
      for (int c = 0; c < CORES; c++) begin
        if (THREAD_ACCEPT[c] || !THREAD_REQ[c].valid) begin
          wait_q[c] <= 4'h0;
        end else begin
          wait_q[c] <= wait_q[c] + 4'h1;
        end
      end
    end
  end
  // busy controller: holds the request back for a set number of cycles
  always_comb begin
    for (int c = 0; c < CORES; c++) begin
      THREAD_ACCEPT[c] = THREAD_REQ[c].valid &&
        wait_q[c] >= ACCEPT_DELAY;
    end
  end
endmodule
`default_nettype wire

/* File: verification/testbench.sv */
// self-checking bench for the shared gpio block
// assumes the board model closes the pin and thread-start loops
`default_nettype none
module testbench
  import gpio_event_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK = 1'b0;
  logic RSTN = 1'b0;
  core_req_t [3:0] req_s = '0;
  core_rsp_t [3:0] rsp_s;
  thread_req_t [3:0] thr_s;
  logic [3:0] acc_s;
  logic [3:0] acc_dly = 4'h0;
  logic [111:0] pin_in, pin_out, pin_oe;
  logic [111:0] ext = '0;
  logic [3:0] was_v = '0;
  logic [31:0] rd_q[$];
  logic [20:0] ev_q[4][$];
  int err_total = 0;
  int cmp_count = 0;
  int cyc = 0;
  always #10 CLK = ~CLK;
  gpio_event_port #(.CORES(4)) dut_u (.CLK(CLK), .RSTN(RSTN),
    .CORE_REQ(req_s), .CORE_RSP(rsp_s), .PIN_IN(pin_in), .PIN_OUT(pin_out),
    .PIN_OE(pin_oe), .THREAD_REQ(thr_s), .THREAD_ACCEPT(acc_s));
  pin_board_model #(.CORES(4)) board_u (.CLK(CLK), .RSTN(RSTN),
    .EXT_LEVEL(ext), .ACCEPT_DELAY(acc_dly), .PIN_OUT(pin_out),
    .PIN_OE(pin_oe), .THREAD_REQ(thr_s), .PIN_IN(pin_in),
    .THREAD_ACCEPT(acc_s));
  // ----------------------------------------------------------
  // tasks
  // ----------------------------------------------------------
  function automatic logic [31:0] ad(int b, logic [7:0] off);
    return BASE_ADDR + BANK_STRIDE * b + {24'h0, off};
  endfunction
  function automatic int pend();
    return rd_q.size() + ev_q[0].size() + ev_q[1].size() + ev_q[2].size() +
      ev_q[3].size();
  endfunction
  task automatic chk(logic [31:0] seen, logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("compares %0d errors %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic wr(int c, logic [31:0] a, logic [31:0] d);
    req_s[c] = '{1'b1, 1'b1, a, d};
    @(negedge CLK);
    req_s[c].req = 1'b0;
    @(negedge CLK);
  endtask
  task automatic rd(int c, logic [31:0] a, logic [31:0] exp);
    rd_q.push_back(exp);
    req_s[c] = '{1'b1, 1'b0, a, 32'h0};
    @(negedge CLK);
    req_s[c].req = 1'b0;
    repeat (9) @(negedge CLK);
  endtask
  // arm a pin that already matches and count cycles to its request
  task automatic arm_now(int c, int b, int pin, logic [13:0] sa);
    int n;
    n = 0;
    ev_q[c].push_back({sa, 7'(pin)});
    req_s[c] = '{1'b1, 1'b1, ad(b, OFF_ARM_HIGH), 32'h80};
    do begin
      @(negedge CLK);
      req_s[c].req = 1'b0;
      n++;
    end while (thr_s[c].valid !== 1'b1 && n < 30);
    chk(n, 9);
  endtask
  // round robin serves one core's pins in index order, so notes come in order
  task automatic ev_take(int c);
    logic [20:0] got;
    got = {thr_s[c].start_addr, thr_s[c].pin_index};
    if (ev_q[c].size() > 0) begin
      chk({11'h0, got}, {11'h0, ev_q[c].pop_front()});
    end else begin
      chk({11'h0, got}, 32'hFFFFFFFF);
    end
  endtask
  // ----------------------------------------------------------
  // result watch and hang guard
  // ----------------------------------------------------------
  always @(negedge CLK) begin
    logic [31:0] exp_r;
    for (int c = 0; c < 4; c++) begin
      if (rsp_s[c].rvalid === 1'b1) begin
        exp_r = rd_q.size() > 0 ? rd_q.pop_front() : 32'hDEADBEEF;
        chk(rsp_s[c].rdata, exp_r);
      end
      if (thr_s[c].valid === 1'b1 && !was_v[c]) begin
        ev_take(c);
      end
      was_v[c] = thr_s[c].valid;
    end
  end
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      print_verdict();
    end
  end
  initial begin
    logic [7:0] d;
    logic [13:0] sa [4];
    void'($urandom(7932));
    repeat (3) @(negedge CLK);
    RSTN = 1'b1;
    chk({30'h0, |pin_oe, |pin_out}, 32'h0);
    for (int b = 0; b < NUM_BANKS; b++) begin
      d = 8'($urandom);
      wr(b % 4, ad(b, OFF_DIR_SET), {24'hFFFFFF, d});
      wr(b % 4, ad(b, OFF_OUT_SET), {24'h0, d});
      chk({pin_oe[b*8 +: 8], pin_out[b*8 +: 8]}, {16'h0, d, d});
      wr(0, ad(b, OFF_DIR_CLR), {24'h0, d & 8'h0F});
      wr(0, ad(b, OFF_OUT_CLR), 32'h0);
      chk({pin_oe[b*8 +: 8], pin_out[b*8 +: 8]}, {16'h0, d & 8'hF0, d});
      wr(0, ad(b, OFF_OUT_CLR), 32'hFF);
      wr(0, ad(b, OFF_DIR_CLR), 32'hFF);
      chk({pin_oe[b*8 +: 8], pin_out[b*8 +: 8]}, 32'h0);
    end
    d = 8'($urandom);
    ext[104 +: 8] = d;
    repeat (8) @(negedge CLK);
    rd(0, ad(13, OFF_PIN_IN), {24'h0, d});
    rd(0, ad(13, OFF_DIR_SET), 32'h0);
    rd(0, ad(2, 8'h50), 32'h0);
    for (int c = 0; c < 4; c++) begin
      sa[c] = 14'($urandom);
      wr(c, BASE_ADDR + EVENT_ADDR_OFF, {18'h0, sa[c]});
    end
    for (int c = 0; c < 4; c++) begin
      rd(c, BASE_ADDR + EVENT_ADDR_OFF, {18'h0, sa[c]});
    end
    ext[31] = 1'b1;
    ext[24] = 1'b1;
    repeat (8) @(negedge CLK);
    arm_now(2, 3, 31, sa[2]);
    repeat (10) @(negedge CLK);
    rd(0, ad(3, OFF_CAPTURE), 32'h01);
    wr(0, ad(3, OFF_CAPTURE), 32'h01);
    rd(0, ad(3, OFF_CAPTURE), 32'h00);
    // pin still high: a new event only after re-arming
    arm_now(1, 3, 31, sa[1]);
    wr(1, ad(4, OFF_ARM_HIGH), 32'h80);
    wr(3, ad(4, OFF_ARM_HIGH), 32'h80);
    ev_q[3].push_back({sa[3], 7'd39});
    ext[39] = 1'b1;
    repeat (20) @(negedge CLK);
    acc_dly = 4'($urandom_range(2, 6));
    for (int p = 0; p < 8; p++) begin
      ev_q[0].push_back({sa[0], 7'(p)});
    end
    ev_q[1].push_back({sa[1], 7'd71});
    wr(0, ad(0, OFF_ARM_LOW), 32'hFF);
    wr(1, ad(8, OFF_ARM_LOW), 32'h80);
    wr(2, ad(10, OFF_ARM_LOW), 32'hFF);
    rd(0, ad(10, OFF_CAPTURE), 32'h0);
    for (int n = 0; n < 400 && pend() > 0; n++) begin
      @(negedge CLK);
    end
    repeat (30) @(negedge CLK);
    chk(pend(), 0);
    print_verdict();
  end
endmodule
`default_nettype wire
